// ---- dv/sscp_port_asserts.sv ----
`timescale 1ns/10ps
module sscp_port_asserts (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   sclk_i,
  input wire logic                   chip_select_n_i,
  input wire logic                   reset_n_input_i,
  input wire logic                   so_o,
  input wire logic                   so_oe_o,
  input wire logic                   spi_enabled_o,
  input wire logic                   fail_mode_o,
  input wire sscp_pkg::sscp_cfg_type settings_o
);
  import sscp_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_idle_a:
    assert property (chip_select_n_i [*5] |-> !so_oe_o) else $error("so driven, cs high");
  oe_active_a:
    assert property ((!chip_select_n_i && spi_enabled_o) [*5] |-> so_oe_o)
      else $error("so not driven in frame");
  so_hold_a:
    assert property (!sclk_i [*6] ##1 (so_oe_o && $past(so_oe_o)) |-> $stable(so_o))
      else $error("so moved without clock rise");
  port_on_a:
    assert property (reset_n_input_i [*3] |-> spi_enabled_o) else $error("port not enabled");
  port_off_a:
    assert property (!reset_n_input_i [*4] |-> !spi_enabled_o && !so_oe_o)
      else $error("port active while held");
  held_clear_a:
    assert property (!reset_n_input_i [*4] |-> settings_o == '0 && !fail_mode_o)
      else $error("settings kept while held");
  idle_stable_a:
    assert property ((chip_select_n_i && reset_n_input_i) [*5] ##1 !fail_mode_o
      |-> $stable(settings_o)) else $error("settings moved outside frame end");
  fail_clear_a:
    assert property ($rose(fail_mode_o) |-> settings_o == '0) else $error("fail kept settings");
endmodule

bind sscp_port sscp_port_asserts i_sscp_port_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i),
  .reset_n_input_i(reset_n_input_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .spi_enabled_o(spi_enabled_o), .fail_mode_o(fail_mode_o), .settings_o(settings_o));

// ---- dv/sscp_port_tb.sv ----
`timescale 1ns/10ps
module sscp_port_tb;
  import sscp_pkg::*;
  logic          clk_i, rst_i, sclk, si, cs_n, rst_pin, so, so_oe, wake, spi_en, fail;
  logic [3:0]    wake_in;
  logic [15:0]   rx;
  sscp_diag_type diag;
  sscp_cfg_type  cfg, exp;
  int            bad_count, n_checks, cycles;

  sscp_port #(.WD_SHORT_CYC(2000), .WD_LONG_CYC(4000)) i_sscp_port (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .si_i(si), .chip_select_n_i(cs_n),
    .reset_n_input_i(rst_pin), .direct_wake_inputs_i(wake_in), .diag_words_i(diag),
    .so_o(so), .so_oe_o(so_oe), .wake_o(wake), .spi_enabled_o(spi_en),
    .fail_mode_o(fail), .settings_o(cfg));
  sscp_spi_master i_master (
    .clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .sclk_o(sclk), .si_o(si), .cs_n_o(cs_n));

  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [191:0] e, input logic [191:0] g);
    n_checks++;
    if (e !== g) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apply(input logic [3:0] a, input logic [10:0] p);
    case (a)
      4'h0: exp.init_config_a = p;
      4'h8: {exp.output_select_flag, exp.channel_on} = p;
      4'h9: if (p[10]) exp.shared_duty_bits = p[7:0];
        else exp.shared_duty_enable = p[5:0];
      4'ha: if (p[10]) exp.overcurrent_config_b = p[9:0];
        else exp.overcurrent_config_a = p[9:0];
      4'hc: if (p[10]) exp.prescaler_config_b = p[1:0];
        else exp.prescaler_config_a = p[9:0];
      4'hd: if (p[10]) exp.led_open_load_control = p[5:0];
        else exp.open_load_control = p[9:0];
      4'h1: exp.init_config_b = p;
      4'hb: exp.direct_input_control = p[7:0];
      4'he: exp.duty_step_control = p;
      4'hf: ;
      default: exp.channel_control[a - 4'h2] = p;
    endcase
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("settings", 192'(exp), 192'(cfg));
    check("so_oe", 192'(1'b0), 192'(so_oe));
    check("fail", 192'(1'b0), 192'(fail));
  endtask
  task automatic t_pin;
    rst_pin = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wake_in = 4'h1 << k;
      i_master.pause(4);
      check("wake", 192'(1'b1), 192'(wake));
    end
    check("spi_en", 192'(1'b0), 192'(spi_en));
    wake_in = 4'h0;
    i_master.pause(5);
    check("wake", 192'(1'b0), 192'(wake));
    rst_pin = 1'b1;
    i_master.pause(5);
    check("spi_en", 192'(1'b1), 192'(spi_en));
    check("wake", 192'(1'b1), 192'(wake));
  endtask
  task automatic t_write;
    logic [14:0] tbl [15];
    logic [15:0] er;
    tbl = '{{4'h3, 11'h6a5}, {4'h0, 11'h0e5}, {4'h7, 11'h35a}, {4'hf, 11'h7ff},
            {4'h8, 11'h5c3}, {4'h9, 11'h02b}, {4'h9, 11'h4c3}, {4'ha, 11'h155},
            {4'ha, 11'h6aa}, {4'hc, 11'h3cc}, {4'hc, 11'h403}, {4'hd, 11'h21e},
            {4'hd, 11'h42d}, {4'h2, 11'h1f0}, {4'h1, 11'h2d2}};
    for (int i = 0; i < 15; i++) begin
      // a diagnostic word that changes mid-run must reach the next reply
      if (i == 8) begin
        diag[5] = 16'hc3a5;
      end
      er = diag[exp.init_config_a.next_readout_address];
      i_master.xfer(tbl[i][14:11], tbl[i][10:0], 16, rx);
      apply(tbl[i][14:11], tbl[i][10:0]);
      check("reply", 192'(er), 192'(rx));
      check("settings", 192'(exp), 192'(cfg));
    end
  endtask
  task automatic t_watchdog;
    i_master.pause(1850);
    check("fail", 192'(1'b0), 192'(fail));
    i_master.pause(250);
    exp = '0;
    check("fail", 192'(1'b1), 192'(fail));
    check("settings", 192'(exp), 192'(cfg));
  endtask
  task automatic t_recover;
    i_master.wd_bit = 1'b0;
    i_master.xfer(4'h0, 11'h003, 16, rx);
    check("reply", 192'(diag[5]), 192'(rx));
    check("fail", 192'(1'b1), 192'(fail));
    i_master.xfer(4'h0, 11'h003, 16, rx);
    check("reply", 192'(diag[3]), 192'(rx));
    check("fail", 192'(1'b0), 192'(fail));
    check("settings", 192'(exp), 192'(cfg));
  endtask
  task automatic t_modulo;
    logic [15:0] w;
    i_master.xfer(4'h5, 11'h2aa, 16, rx);
    apply(4'h5, 11'h2aa);
    check("channel", 192'(11'h2aa), 192'(cfg.channel_control[3]));
    // long timeout and a single read of word 7
    i_master.xfer(4'h0, 11'h417, 16, rx);
    apply(4'h0, 11'h417);
    i_master.xfer(4'hb, 11'h0c3, 16, rx);
    apply(4'hb, 11'h0c3);
    check("reply", 192'(diag[7]), 192'(rx));
    // two chained frames: own word first, then the input passes through
    w = {4'he, i_master.wd_bit, 11'h5a5};
    i_master.xfer(4'he, 11'h5a5, 32, rx);
    apply(4'he, 11'h5a5);
    check("chain", 192'(w), 192'(rx));
    check("settings", 192'(exp), 192'(cfg));
    i_master.pause(2900);
    check("fail", 192'(1'b0), 192'(fail));
    i_master.xfer(4'h5, 11'h155, 15, rx);
    exp = '0;
    check("fail", 192'(1'b1), 192'(fail));
    check("settings", 192'(exp), 192'(cfg));
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    rst_i = 1'b1;
    rst_pin = 1'b1;
    wake_in = 4'h0;
    exp = '0;
    for (int k = 0; k < 16; k++) begin
      diag[k] = {4'(k), ~4'(k), 8'h5a};
    end
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    i_master.pause(4);
    t_reset();
    t_pin();
    t_write();
    t_watchdog();
    t_recover();
    t_modulo();
    print_verdict();
  end
endmodule

// ---- dv/sscp_spi_master.sv ----
`timescale 1ns/10ps
module sscp_spi_master (
  input  wire logic clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      sclk_o,
  output logic      si_o,
  output logic      cs_n_o
);
  logic wd_bit;
  initial begin
    sclk_o = 1'b0;
    si_o   = 1'b0;
    cs_n_o = 1'b1;
    wd_bit = 1'b1;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic xfer(input logic [3:0] a, input logic [10:0] p, input int n,
                      output logic [15:0] rx);
    logic [15:0] w;
    w = {a, wd_bit, p};
    rx = 'x;
    cs_n_o = 1'b0;
    pause(5);
    for (int i = 0; i < n; i++) begin
      si_o = w[15 - (i % 16)];
      pause(4);
      sclk_o = 1'b1;
      pause(4);
      sclk_o = 1'b0;
      rx = {rx[14:0], so_oe_i ? so_i : 1'bx};
    end
    pause(5);
    cs_n_o = 1'b1;
    // released line shows the inverse of its last value
    si_o = ~si_o;
    wd_bit = ~wd_bit;
    pause(6);
  endtask
endmodule

// ---- verilog/sscp_pkg.sv ----
package sscp_pkg;

  typedef enum logic [1:0] {
    SSCP_NORMAL = 2'b00,
    SSCP_FAIL   = 2'b01,
    SSCP_ARMED  = 2'b10
  } sscp_mode_type;

  typedef struct packed {
    logic [1:0] channel_phase;
    logic       channel_on;
    logic [7:0] channel_duty_bits;
  } sscp_chan_type;

  typedef struct packed {
    logic       watchdog_timeout_select;
    logic [1:0] sync_delay_setting;
    logic [2:0] sense_select;
    logic       single_read_mode;
    logic [3:0] next_readout_address;
  } sscp_init_a_type;

  typedef struct packed {
    sscp_init_a_type        init_config_a;
    logic [10:0]            init_config_b;
    sscp_chan_type [5:0]    channel_control;
    logic [4:0]             output_select_flag;
    logic [5:0]             channel_on;
    logic [5:0]             shared_duty_enable;
    logic [7:0]             shared_duty_bits;
    logic [9:0]             overcurrent_config_a;
    logic [9:0]             overcurrent_config_b;
    logic [7:0]             direct_input_control;
    logic [9:0]             prescaler_config_a;
    logic [1:0]             prescaler_config_b;
    logic [9:0]             open_load_control;
    logic [5:0]             led_open_load_control;
    logic [10:0]            duty_step_control;
  } sscp_cfg_type;

  typedef logic [15:0][15:0] sscp_diag_type;

endpackage

// ---- verilog/sscp_port.sv ----
`timescale 1ns/10ps
`include "sscp_regs.svh"

// Behaviour
// - frames are 16 bits full duplex; several devices may share one chain
// - serial input is sampled into the shift register on each rising clock edge
// - serial output changes on rising clock edge; master captures on falling edge
// - falling chip select loads the output shift register with the reply word
// - bits shift only while chip select is low
// - rising chip select transfers the frame into the addressed register
// - with chip select high, clock and input are ignored and output floats
// - reset pin low clears port and fault state; wake follows direct inputs
// - reset pin high means awake and serial port enabled
// - traffic is checked for plausibility; failures force Fail mode
// - top four frame bits are the register address
// - no watchdog toggle before the selected timeout flags a serial failure
// - all register fields reset to zero
// - addresses 2 to 7: phase, channel on and duty per channel
// - at 9, 10, 12, 13 payload bit 10 picks the sub-register
// - address 8 holds five select flags and six channel-on bits
// - register 0 holds timeout select, sync delay, sense, single read, readout address
// - address 15 is test mode and is ignored
// - a clock count not a multiple of sixteen is a serial failure
// - entering Fail mode clears written settings, keeps diagnostic words
// - the reply word is the diagnostic word picked by the readout address
module sscp_port #(
  parameter int unsigned WD_SHORT_CYC = `SSCP_WD_SHORT_US * `SSCP_CLK_MHZ,
  parameter int unsigned WD_LONG_CYC  = `SSCP_WD_LONG_US * `SSCP_CLK_MHZ
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  sclk_i,
  input  wire logic                  si_i,
  input  wire logic                  chip_select_n_i,
  input  wire logic                  reset_n_input_i,
  input  wire logic [3:0]            direct_wake_inputs_i,
  input  wire sscp_pkg::sscp_diag_type diag_words_i,
  output logic                       so_o,
  output logic                       so_oe_o,
  output logic                       wake_o,
  output logic                       spi_enabled_o,
  output logic                       fail_mode_o,
  output sscp_pkg::sscp_cfg_type     settings_o
);
  import sscp_pkg::*;

  localparam int WD_CNT_W = $clog2(WD_LONG_CYC + 1);

  //////////////////////////////////////////////////////////////////////////////
  // edge finders on two samples, newer sample in bit 0

  function automatic logic rose_of(input logic [1:0] pair);
    return pair[0] & ~pair[1];
  endfunction

  function automatic logic fell_of(input logic [1:0] pair);
    return ~pair[0] & pair[1];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0]    sclk_sync_reg;
  logic [2:0]    csn_sync_reg;
  logic [1:0]    si_sync_reg;
  logic [1:0]    rstn_sync_reg;
  logic [1:0]    wake0_sync_reg;
  logic [1:0]    wake1_sync_reg;
  logic [1:0]    wake2_sync_reg;
  logic [1:0]    wake3_sync_reg;

  // chip select resets high so leaving reset is not taken as a frame start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync_reg <= 3'h0;
      csn_sync_reg  <= 3'h7;
      si_sync_reg   <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      csn_sync_reg  <= {csn_sync_reg[1:0], chip_select_n_i};
      si_sync_reg   <= {si_sync_reg[0], si_i};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rstn_sync_reg  <= 2'h0;
      wake0_sync_reg <= 2'h0;
      wake1_sync_reg <= 2'h0;
      wake2_sync_reg <= 2'h0;
      wake3_sync_reg <= 2'h0;
    end else begin
      rstn_sync_reg  <= {rstn_sync_reg[0], reset_n_input_i};
      wake0_sync_reg <= {wake0_sync_reg[0], direct_wake_inputs_i[0]};
      wake1_sync_reg <= {wake1_sync_reg[0], direct_wake_inputs_i[1]};
      wake2_sync_reg <= {wake2_sync_reg[0], direct_wake_inputs_i[2]};
      wake3_sync_reg <= {wake3_sync_reg[0], direct_wake_inputs_i[3]};
    end
  end

  logic          port_en;
  logic          sclk_rise;
  logic          cs_fall;
  logic          cs_rise;
  logic          cs_active;
  logic          direct_wake;

  assign port_en     = rstn_sync_reg[1];
  assign direct_wake = wake0_sync_reg[1] | wake1_sync_reg[1]
                     | wake2_sync_reg[1] | wake3_sync_reg[1];
  assign cs_active   = port_en & ~csn_sync_reg[1];
  assign sclk_rise   = cs_active & rose_of(sclk_sync_reg[2:1]);
  assign cs_fall     = port_en & fell_of(csn_sync_reg[2:1]);
  assign cs_rise     = port_en & rose_of(csn_sync_reg[2:1]);

  //////////////////////////////////////////////////////////////////////////////
  // shift path

  logic [15:0]   shift_reg;
  logic          so_reg;
  logic          so_oe_reg;
  logic [3:0]    bit_cnt_reg;
  logic          clocked_reg;
  logic [3:0]    readout_addr_reg;

  // pin edges show up two to three clocks late, so each serial clock phase
  // and the chip select setup must last at least four system clocks
  // load own reply, shift through
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= 16'h0000;
      so_reg    <= 1'b0;
    end else if (!port_en) begin
      shift_reg <= 16'h0000;
      so_reg    <= 1'b0;
    end else if (cs_fall) begin
      shift_reg <= diag_words_i[readout_addr_reg];
    end else if (sclk_rise) begin
      // sample input, drive next output bit
      shift_reg <= {shift_reg[14:0], si_sync_reg[1]};
      so_reg    <= shift_reg[15];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= cs_active;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 4'h0;
      clocked_reg <= 1'b0;
    end else if (!port_en || cs_fall) begin
      bit_cnt_reg <= 4'h0;
      clocked_reg <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      clocked_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame end

  logic          frame_ok;
  logic          mod_err;
  logic [3:0]    frame_addr;
  logic          frame_wd;
  logic [10:0]   payload;

  // a chip select rise with no clocks is a plain deselect, not an error
  assign frame_ok   = cs_rise & clocked_reg & (bit_cnt_reg == 4'h0);
  assign mod_err    = cs_rise & clocked_reg & (bit_cnt_reg != 4'h0);
  assign frame_addr = shift_reg[`SSCP_ADDR_MSB:`SSCP_ADDR_LSB];
  assign frame_wd   = shift_reg[`SSCP_WD_BIT];
  assign payload    = shift_reg[`SSCP_PAYLOAD_MSB:0];

  //////////////////////////////////////////////////////////////////////////////
  // watchdog and mode

  sscp_mode_type mode_reg;
  sscp_cfg_type  cfg_reg;
  logic [WD_CNT_W-1:0] wd_cnt_reg;
  logic          wd_last_reg;
  logic          wd_toggled;
  logic          wd_timeout;
  logic [WD_CNT_W-1:0] wd_limit;
  logic          enter_fail;

  // a frame that keeps the old watchdog bit still writes; only the timer catches it
  assign wd_toggled = frame_ok & (frame_wd != wd_last_reg);
  assign wd_limit   = cfg_reg.init_config_a.watchdog_timeout_select
                    ? WD_CNT_W'(WD_LONG_CYC) : WD_CNT_W'(WD_SHORT_CYC);
  // toggle missing for a whole timeout
  assign wd_timeout = (wd_cnt_reg >= wd_limit);

  always_comb begin
    enter_fail = 1'b0;
    if (mode_reg != SSCP_FAIL) begin
      enter_fail = mod_err | wd_timeout;
    end
  end

  // timer restarts on each toggled frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_cnt_reg  <= '0;
      wd_last_reg <= 1'b0;
    end else if (!port_en || enter_fail) begin
      wd_cnt_reg  <= '0;
      wd_last_reg <= 1'b0;
    end else if (mode_reg == SSCP_FAIL) begin
      wd_cnt_reg  <= '0;
      if (frame_ok) begin
        wd_last_reg <= frame_wd;
      end
    end else if (wd_toggled) begin
      wd_cnt_reg  <= '0;
      wd_last_reg <= frame_wd;
    end else if (!wd_timeout) begin
      wd_cnt_reg  <= wd_cnt_reg + WD_CNT_W'(1);
    end
  end

  // recovery: watchdog 0 frame, then watchdog 1 frame in time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= SSCP_NORMAL;
    end else if (!port_en) begin
      mode_reg <= SSCP_NORMAL;
    end else begin
      unique case (mode_reg)
        SSCP_NORMAL: begin
          if (enter_fail) begin
            mode_reg <= SSCP_FAIL;
          end
        end
        SSCP_FAIL: begin
          if (frame_ok && !frame_wd) begin
            mode_reg <= SSCP_ARMED;
          end
        end
        SSCP_ARMED: begin
          if (enter_fail) begin
            mode_reg <= SSCP_FAIL;
          end else if (frame_ok && frame_wd) begin
            mode_reg <= SSCP_NORMAL;
          end
        end
        default: begin
          mode_reg <= SSCP_FAIL;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // readout address

  // single read mode drops back to word 0 after one reply
  // readout address also accepted in Fail mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      readout_addr_reg <= 4'h0;
    end else if (!port_en) begin
      readout_addr_reg <= 4'h0;
    end else if (frame_ok && frame_addr == `SSCP_ADDR_INIT_A) begin
      readout_addr_reg <= payload[3:0];
    end else if (frame_ok && cfg_reg.init_config_a.single_read_mode) begin
      readout_addr_reg <= 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // settings registers

  logic          write_en;
  logic          sub_sel;
  logic [2:0]    chan_idx;

  // writes are refused in Fail and while arming the return to Normal
  assign write_en = frame_ok & (mode_reg == SSCP_NORMAL);
  assign sub_sel  = payload[`SSCP_SUB_SEL_BIT];
  assign chan_idx = 3'(frame_addr - `SSCP_ADDR_CHAN_FIRST);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= `SSCP_CFG_RESET;
    end else if (!port_en || enter_fail) begin
      cfg_reg <= `SSCP_CFG_RESET;
    end else if (write_en) begin
      unique case (frame_addr)
        `SSCP_ADDR_INIT_A: cfg_reg.init_config_a <= sscp_init_a_type'(payload);
        `SSCP_ADDR_INIT_B: cfg_reg.init_config_b <= payload;
        `SSCP_ADDR_OUT_CTL: begin
          cfg_reg.output_select_flag <= payload[10:6];
          cfg_reg.channel_on         <= payload[5:0];
        end
        `SSCP_ADDR_SHARED: begin
          if (sub_sel) begin
            cfg_reg.shared_duty_bits <= payload[7:0];
          end else begin
            cfg_reg.shared_duty_enable <= payload[5:0];
          end
        end
        `SSCP_ADDR_OVERCUR: begin
          if (sub_sel) begin
            cfg_reg.overcurrent_config_b <= payload[9:0];
          end else begin
            cfg_reg.overcurrent_config_a <= payload[9:0];
          end
        end
        `SSCP_ADDR_INPUT_EN: cfg_reg.direct_input_control <= payload[7:0];
        `SSCP_ADDR_PRESCALE: begin
          if (sub_sel) begin
            cfg_reg.prescaler_config_b <= payload[1:0];
          end else begin
            cfg_reg.prescaler_config_a <= payload[9:0];
          end
        end
        `SSCP_ADDR_OPEN_LOAD: begin
          if (sub_sel) begin
            cfg_reg.led_open_load_control <= payload[5:0];
          end else begin
            cfg_reg.open_load_control <= payload[9:0];
          end
        end
        `SSCP_ADDR_STEP: cfg_reg.duty_step_control <= payload;
        `SSCP_ADDR_TEST: begin
        end
        default: cfg_reg.channel_control[chan_idx] <= sscp_chan_type'(payload);
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign so_o          = so_reg;
  assign so_oe_o       = so_oe_reg;
  // wake from reset pin or direct inputs
  assign wake_o        = port_en | direct_wake;
  assign spi_enabled_o = port_en;
  assign fail_mode_o   = (mode_reg != SSCP_NORMAL);
  assign settings_o    = cfg_reg;

endmodule

// ---- verilog/sscp_regs.svh ----
`ifndef SSCP_REGS_SVH
`define SSCP_REGS_SVH

// frame layout
`define SSCP_FRAME_BITS       16
`define SSCP_ADDR_MSB         15
`define SSCP_ADDR_LSB         12
`define SSCP_WD_BIT           11
`define SSCP_PAYLOAD_MSB      10
`define SSCP_SUB_SEL_BIT      10

// register addresses
`define SSCP_ADDR_INIT_A      4'h0
`define SSCP_ADDR_INIT_B      4'h1
`define SSCP_ADDR_CHAN_FIRST  4'h2
`define SSCP_ADDR_CHAN_LAST   4'h7
`define SSCP_ADDR_OUT_CTL     4'h8
`define SSCP_ADDR_SHARED      4'h9
`define SSCP_ADDR_OVERCUR     4'ha
`define SSCP_ADDR_INPUT_EN    4'hb
`define SSCP_ADDR_PRESCALE    4'hc
`define SSCP_ADDR_OPEN_LOAD   4'hd
`define SSCP_ADDR_STEP        4'he
`define SSCP_ADDR_TEST        4'hf

// reset value of every setting
`define SSCP_CFG_RESET        '0

// watchdog timeouts, in microseconds, and clock rate
`define SSCP_CLK_MHZ          10
`define SSCP_WD_SHORT_US      10000
`define SSCP_WD_LONG_US       50000

`endif
